/* verilog/dcsr_bank.v */
// Overview of operation
// - run command 0008H ends jog, stops motor
// - frequency reference at FREQUENCY_REFERENCE, 0.01 Hz
// - PID setpoint at PID_SETPOINT, 0 to 1000
// - PID feedback at PID_FEEDBACK, 0 to 1000
// - signed torque setpoint TORQUE_SETPOINT, +-3000
// - forward frequency ceiling at FORWARD_FREQ_CEILING
// - reverse frequency ceiling at REVERSE_FREQ_CEILING
// - motoring torque ceiling MOTORING_TORQUE_CEILING, 0 to 3000
// - braking torque ceiling BRAKING_TORQUE_CEILING, 0 to 3000
// - control word bits 1..0 select motor
// - control word bit 2 disables torque control
// - control word bit 3 clears power total
// - control word bit 4 requests pre-excitation
// - control word bit 5 requests DC braking
// - virtual input image VIRTUAL_INPUT_IMAGE, ten bits
// - virtual output image VIRTUAL_OUTPUT_IMAGE, four bits
// - voltage setpoint VOLTAGE_SETPOINT, 0 to 1000
// - signed analog output one setpoint ANALOG_OUT_ONE_SETPOINT
// - continuous write carries at most 16 words
// - single or continuous write commands store
`timescale 1ns/1ps
`include "dcsr_regs.vh"

module dcsr_bank (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        acc_valid,
  input  wire [7:0]  acc_func,
  input  wire [15:0] acc_addr,
  input  wire [15:0] acc_wdata,
  input  wire [15:0] acc_qty,
  input  wire [15:0] max_out_freq,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_code,
  output reg  [15:0] rsp_rdata,
  output reg         jog_stop_req,
  output reg         power_accum_clear,
  output wire [15:0] frequency_reference,
  output wire [15:0] pid_setpoint,
  output wire [15:0] pid_feedback,
  output wire [15:0] torque_setpoint,
  output wire [15:0] forward_freq_ceiling,
  output wire [15:0] reverse_freq_ceiling,
  output wire [15:0] motoring_torque_ceiling,
  output wire [15:0] braking_torque_ceiling,
  output wire [1:0]  motor_select,
  output wire        torque_ctrl_disable,
  output wire        pre_excite_req,
  output wire        dc_brake_req,
  output wire [9:0]  virtual_input_image,
  output wire [3:0]  virtual_output_image,
  output wire [15:0] voltage_setpoint,
  output wire [15:0] analog_out_one_setpoint
);

  // ==========================================================
  // decode
  wire [15:0] bank [0:12];
  reg  [15:0] run_command;
  reg  [15:0] rel_addr;
  reg  [3:0]  idx;
  reg         in_bank;
  reg         is_run;
  reg         is_write;
  reg         in_range;
  reg  [15:0] keep_mask;
  reg  [7:0]  next_code;
  reg  [15:0] next_rdata;
  reg         do_write;

  always @* begin
    rel_addr = acc_addr - `DCSR_ADDR_FREQ_REF;
    idx      = rel_addr[3:0];
    in_bank  = (acc_addr >= `DCSR_ADDR_FREQ_REF) &&
               (acc_addr <= `DCSR_ADDR_AO1_SET);
    is_run   = (acc_addr == `DCSR_ADDR_RUN_CMD);
    is_write = (acc_func == `DCSR_FN_WRITE_ONE) ||
               (acc_func == `DCSR_FN_WRITE_MANY);
  end

  // upper bits of narrow registers are dropped on write
  always @* begin
    case (idx)
      `DCSR_IDX_SPECIAL_CTL: keep_mask = `DCSR_MASK_SPECIAL_CTL;
      `DCSR_IDX_VIRT_IN:     keep_mask = `DCSR_MASK_VIRT_IN;
      `DCSR_IDX_VIRT_OUT:    keep_mask = `DCSR_MASK_VIRT_OUT;
      default:               keep_mask = 16'hffff;
    endcase
  end

  // ==========================================================
  // value range check
  always @* begin
    in_range = 1'b1;
    if (is_run) begin
      in_range = (acc_wdata >= `DCSR_RUN_CMD_MIN) &&
                 (acc_wdata <= `DCSR_RUN_CMD_MAX);
    end else begin
      case (idx)
        `DCSR_IDX_FREQ_REF:
          in_range = (acc_wdata <= max_out_freq);
        `DCSR_IDX_FWD_CEIL:
          in_range = (acc_wdata <= max_out_freq);
        `DCSR_IDX_REV_CEIL:
          in_range = (acc_wdata <= max_out_freq);
        `DCSR_IDX_PID_SET:
          in_range = (acc_wdata <= `DCSR_MAX_PERMILLE);
        `DCSR_IDX_PID_FB:
          in_range = (acc_wdata <= `DCSR_MAX_PERMILLE);
        `DCSR_IDX_VOLT_SET:
          in_range = (acc_wdata <= `DCSR_MAX_PERMILLE);
        `DCSR_IDX_MOT_TQ_CEIL:
          in_range = (acc_wdata <= `DCSR_MAX_TORQUE);
        `DCSR_IDX_BRK_TQ_CEIL:
          in_range = (acc_wdata <= `DCSR_MAX_TORQUE);
        `DCSR_IDX_TORQUE_SET:
          in_range = ($signed(acc_wdata) >= $signed(`DCSR_MIN_TORQUE_S)) &&
                     ($signed(acc_wdata) <= $signed(`DCSR_MAX_TORQUE));
        `DCSR_IDX_AO1_SET:
          in_range = ($signed(acc_wdata) >= $signed(`DCSR_MIN_AO_S)) &&
                     ($signed(acc_wdata) <= $signed(`DCSR_MAX_PERMILLE));
        default:
          in_range = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // access check and answer
  always @* begin
    next_code  = `DCSR_EX_NONE;
    next_rdata = 16'h0000;
    do_write   = 1'b0;
    if (!is_write && (acc_func != `DCSR_FN_READ)) begin
      next_code = `DCSR_EX_FUNC;
    end else if (!in_bank && !is_run) begin
      next_code = `DCSR_EX_ADDR;
    end else if ((acc_func == `DCSR_FN_WRITE_MANY) &&
                 ((acc_qty == 16'h0000) ||
                  (acc_qty > `DCSR_MAX_WRITE_QTY))) begin
      next_code = `DCSR_EX_VALUE;
    end else if (is_write && !in_range) begin
      next_code = `DCSR_EX_VALUE;
    end else if (is_write) begin
      do_write   = 1'b1;
      next_rdata = acc_wdata;
    end else if (is_run) begin
      next_rdata = run_command;
    end else begin
      next_rdata = bank[idx];
    end
  end

  // ==========================================================
  // bank storage
  genvar gi;
  generate
    for (gi = 0; gi < `DCSR_NUM_REGS; gi = gi + 1) begin : g_reg
      reg [15:0] value;
      always @(posedge clk_sys) begin
        if (rst) begin
          value <= `DCSR_RST_REG;
        end else if (acc_valid && do_write && in_bank && (idx == gi)) begin
          value <= acc_wdata & keep_mask;
        end
      end
      assign bank[gi] = value;
    end
  endgenerate

  // ==========================================================
  // run command, answer and one-cycle strobes
  always @(posedge clk_sys) begin
    if (rst) begin
      run_command       <= `DCSR_RST_RUN_CMD;
      rsp_valid         <= 1'b0;
      rsp_code          <= `DCSR_EX_NONE;
      rsp_rdata         <= 16'h0000;
      jog_stop_req      <= 1'b0;
      power_accum_clear <= 1'b0;
    end else begin
      rsp_valid         <= acc_valid;
      rsp_code          <= acc_valid ? next_code : `DCSR_EX_NONE;
      rsp_rdata         <= acc_valid ? next_rdata : 16'h0000;
      jog_stop_req      <= acc_valid && do_write && is_run &&
                           (acc_wdata == `DCSR_RUN_JOG_STOP);
      power_accum_clear <= acc_valid && do_write && in_bank &&
                           (idx == `DCSR_IDX_SPECIAL_CTL) &&
                           acc_wdata[`DCSR_BIT_POWER_CLEAR];
      if (acc_valid && do_write && is_run) begin
        run_command <= acc_wdata;
      end
    end
  end

  // ==========================================================
  // register images to the drive
  assign frequency_reference     = bank[`DCSR_IDX_FREQ_REF];
  assign pid_setpoint            = bank[`DCSR_IDX_PID_SET];
  assign pid_feedback            = bank[`DCSR_IDX_PID_FB];
  assign torque_setpoint         = bank[`DCSR_IDX_TORQUE_SET];
  assign forward_freq_ceiling    = bank[`DCSR_IDX_FWD_CEIL];
  assign reverse_freq_ceiling    = bank[`DCSR_IDX_REV_CEIL];
  assign motoring_torque_ceiling = bank[`DCSR_IDX_MOT_TQ_CEIL];
  assign braking_torque_ceiling  = bank[`DCSR_IDX_BRK_TQ_CEIL];
  assign motor_select            =
    bank[`DCSR_IDX_SPECIAL_CTL][`DCSR_BIT_MOTOR_HI:`DCSR_BIT_MOTOR_LO];
  assign torque_ctrl_disable     =
    bank[`DCSR_IDX_SPECIAL_CTL][`DCSR_BIT_TQ_DISABLE];
  assign pre_excite_req          =
    bank[`DCSR_IDX_SPECIAL_CTL][`DCSR_BIT_PRE_EXCITE];
  assign dc_brake_req            =
    bank[`DCSR_IDX_SPECIAL_CTL][`DCSR_BIT_DC_BRAKE];
  // bit order: inputs 1-4, pulse a, pulse b, inputs 5-8
  assign virtual_input_image     = bank[`DCSR_IDX_VIRT_IN][9:0];
  // bit order: open collector, pulse out, relay first, relay second
  assign virtual_output_image    = bank[`DCSR_IDX_VIRT_OUT][3:0];
  assign voltage_setpoint        = bank[`DCSR_IDX_VOLT_SET];
  assign analog_out_one_setpoint = bank[`DCSR_IDX_AO1_SET];

endmodule // dcsr_bank

/* verilog/dcsr_regs.vh */
`ifndef DCSR_REGS_VH
`define DCSR_REGS_VH

// ==========================================================
// register addresses
`define DCSR_ADDR_RUN_CMD      16'h2000
`define DCSR_ADDR_FREQ_REF     16'h2001
`define DCSR_ADDR_PID_SET      16'h2002
`define DCSR_ADDR_PID_FB       16'h2003
`define DCSR_ADDR_TORQUE_SET   16'h2004
`define DCSR_ADDR_FWD_CEIL     16'h2005
`define DCSR_ADDR_REV_CEIL     16'h2006
`define DCSR_ADDR_MOT_TQ_CEIL  16'h2007
`define DCSR_ADDR_BRK_TQ_CEIL  16'h2008
`define DCSR_ADDR_SPECIAL_CTL  16'h2009
`define DCSR_ADDR_VIRT_IN      16'h200a
`define DCSR_ADDR_VIRT_OUT     16'h200b
`define DCSR_ADDR_VOLT_SET     16'h200c
`define DCSR_ADDR_AO1_SET      16'h200d

// ==========================================================
// bank indices (address minus first bank address)
`define DCSR_NUM_REGS          13
`define DCSR_IDX_FREQ_REF      4'd0
`define DCSR_IDX_PID_SET       4'd1
`define DCSR_IDX_PID_FB        4'd2
`define DCSR_IDX_TORQUE_SET    4'd3
`define DCSR_IDX_FWD_CEIL      4'd4
`define DCSR_IDX_REV_CEIL      4'd5
`define DCSR_IDX_MOT_TQ_CEIL   4'd6
`define DCSR_IDX_BRK_TQ_CEIL   4'd7
`define DCSR_IDX_SPECIAL_CTL   4'd8
`define DCSR_IDX_VIRT_IN       4'd9
`define DCSR_IDX_VIRT_OUT      4'd10
`define DCSR_IDX_VOLT_SET      4'd11
`define DCSR_IDX_AO1_SET       4'd12

// ==========================================================
// reset values
`define DCSR_RST_REG           16'h0000
`define DCSR_RST_RUN_CMD       16'h0000

// ==========================================================
// field layout
`define DCSR_MASK_SPECIAL_CTL  16'h003f
`define DCSR_MASK_VIRT_IN      16'h03ff
`define DCSR_MASK_VIRT_OUT     16'h000f
`define DCSR_BIT_MOTOR_LO      0
`define DCSR_BIT_MOTOR_HI      1
`define DCSR_BIT_TQ_DISABLE    2
`define DCSR_BIT_POWER_CLEAR   3
`define DCSR_BIT_PRE_EXCITE    4
`define DCSR_BIT_DC_BRAKE      5

// ==========================================================
// value ranges
`define DCSR_MAX_PERMILLE      16'h03e8
`define DCSR_MAX_TORQUE        16'h0bb8
`define DCSR_MIN_TORQUE_S      16'hf448
`define DCSR_MIN_AO_S          16'hfc18
`define DCSR_RUN_JOG_STOP      16'h0008
`define DCSR_RUN_CMD_MAX       16'h0008
`define DCSR_RUN_CMD_MIN       16'h0001

// ==========================================================
// command codes and exception codes
`define DCSR_FN_READ           8'h03
`define DCSR_FN_WRITE_ONE      8'h06
`define DCSR_FN_WRITE_MANY     8'h10
`define DCSR_MAX_WRITE_QTY     16'h0010
`define DCSR_EX_NONE           8'h00
`define DCSR_EX_FUNC           8'h01
`define DCSR_EX_ADDR           8'h02
`define DCSR_EX_VALUE          8'h03

`endif

/* tb/dcsr_bank_sva.sv */
`timescale 1ns/1ps
module dcsr_bank_sva (
  input wire        clk_sys,
  input wire        rst,
  input wire        acc_valid,
  input wire [7:0]  acc_func,
  input wire [15:0] acc_addr,
  input wire [15:0] acc_wdata,
  input wire [15:0] acc_qty,
  input wire [15:0] max_out_freq,
  input wire        rsp_valid,
  input wire [7:0]  rsp_code,
  input wire        jog_stop_req,
  input wire        power_accum_clear,
  input wire [15:0] frequency_reference,
  input wire [15:0] pid_setpoint,
  input wire [9:0]  virtual_input_image,
  input wire        dc_brake_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // single writes, response timing, input hold, continuous write quantity
  sequence s_wr(a);
    acc_valid && acc_func == 8'h06 && acc_addr == a;
  endsequence
  property p_rsp; rsp_valid == $past(acc_valid); endproperty
  property p_jog; s_wr(16'h2000) ##0 acc_wdata == 16'h0008 |=> jog_stop_req; endproperty
  property p_jog_src; jog_stop_req |-> $past(acc_wdata) == 16'h0008 && $past(acc_addr) == 16'h2000; endproperty
  property p_freq;
    s_wr(16'h2001) ##0 acc_wdata <= max_out_freq |=> frequency_reference == $past(acc_wdata) && rsp_code == 8'h00;
  endproperty
  property p_freq_err;
    s_wr(16'h2001) ##0 acc_wdata > max_out_freq |=> rsp_code == 8'h03 && $stable(frequency_reference);
  endproperty
  property p_pid_err; s_wr(16'h2002) ##0 acc_wdata > 16'h03e8 |=> rsp_code == 8'h03 && $stable(pid_setpoint); endproperty
  property p_pclr; s_wr(16'h2009) ##0 acc_wdata[3] |=> power_accum_clear; endproperty
  property p_brake; s_wr(16'h2009) |=> dc_brake_req == $past(acc_wdata[5]); endproperty
  property p_vin; !(acc_valid && acc_addr == 16'h200a) |=> $stable(virtual_input_image); endproperty
  property p_qty; acc_valid && acc_func == 8'h10 && (acc_qty == 16'h0000 || acc_qty > 16'h0010) |=> rsp_code == 8'h03; endproperty
  a_rsp: assert property (p_rsp) else $error("response not one cycle after access");
  a_jog: assert property (p_jog) else $error("jog stop not raised");
  a_jog_src: assert property (p_jog_src) else $error("jog stop without its command");
  a_freq: assert property (p_freq) else $error("frequency reference not stored");
  a_freq_err: assert property (p_freq_err) else $error("frequency above maximum accepted");
  a_pid_err: assert property (p_pid_err) else $error("pid setpoint above 1000 accepted");
  a_pclr: assert property (p_pclr) else $error("power clear pulse missing");
  a_brake: assert property (p_brake) else $error("dc brake level wrong");
  a_vin: assert property (p_vin) else $error("virtual inputs changed without write");
  a_qty: assert property (p_qty) else $error("bad write quantity accepted");
endmodule // dcsr_bank_sva

bind dcsr_bank dcsr_bank_sva dcsr_bank_sva_i (.clk_sys, .rst, .acc_valid, .acc_func, .acc_addr, .acc_wdata, .acc_qty,
  .max_out_freq, .rsp_valid, .rsp_code, .jog_stop_req, .power_accum_clear, .frequency_reference, .pid_setpoint,
  .virtual_input_image, .dc_brake_req);

/* tb/dcsr_master.sv */
`timescale 1ns/1ps
module dcsr_master (
  input  wire        clk_sys,
  input  wire        rsp_valid,
  input  wire [7:0]  rsp_code,
  input  wire [15:0] rsp_rdata,
  output reg         acc_valid = 1'b0,
  output reg  [7:0]  acc_func  = 8'h00,
  output reg  [15:0] acc_addr  = 16'h0000,
  output reg  [15:0] acc_wdata = 16'h0000,
  output reg  [15:0] acc_qty   = 16'h0001
);
  // ==========================================================
  // one register access, answer taken one cycle later
  task xfer(input [7:0] f, input [15:0] a, input [15:0] d, input [15:0] q, output [7:0] c, output [15:0] r);
    @(posedge clk_sys);
    acc_valid <= 1'b1;
    acc_func <= f;
    acc_addr <= a;
    acc_wdata <= d;
    acc_qty <= q;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    #1;
    c = rsp_valid ? rsp_code : 8'hee;
    r = rsp_rdata;
  endtask
endmodule // dcsr_master

/* tb/tb_dcsr_bank.sv */
`timescale 1ns/1ps
module tb_dcsr_bank;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] max_out_freq = 16'h1388;
  wire         acc_valid, rsp_valid, jog_stop_req, power_accum_clear, torque_ctrl_disable, pre_excite_req, dc_brake_req;
  wire  [7:0]  acc_func, rsp_code;
  wire  [15:0] acc_addr, acc_wdata, acc_qty, rsp_rdata, frequency_reference, pid_setpoint, pid_feedback;
  wire  [15:0] torque_setpoint, forward_freq_ceiling, reverse_freq_ceiling, motoring_torque_ceiling;
  wire  [15:0] braking_torque_ceiling, voltage_setpoint, analog_out_one_setpoint;
  wire  [1:0]  motor_select;
  wire  [9:0]  virtual_input_image;
  wire  [3:0]  virtual_output_image;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [7:0]  code;
  logic [15:0] rdata;
  // {func, addr, wdata, qty, code, rdata}
  logic [79:0] rows [0:20] = '{
    80'h06_2001_1388_0001_00_0000, 80'h06_2001_1389_0001_03_0000, 80'h03_2001_0000_0001_00_1388,
    80'h06_2004_f448_0001_00_0000, 80'h06_2004_f447_0001_03_0000, 80'h06_2007_0bb9_0001_03_0000,
    80'h06_2008_0bb8_0001_00_0000, 80'h03_2008_0000_0001_00_0bb8, 80'h06_200d_fc18_0001_00_0000,
    80'h03_200d_0000_0001_00_fc18, 80'h06_200c_03e9_0001_03_0000, 80'h06_200a_ffff_0001_00_0000,
    80'h03_200a_0000_0001_00_03ff, 80'h06_200b_00ff_0001_00_0000, 80'h03_200b_0000_0001_00_000f,
    80'h10_2002_03e8_0002_00_0000, 80'h10_2003_0001_0002_00_0000, 80'h10_2005_0001_0011_03_0000,
    80'h03_2002_0000_0001_00_03e8, 80'h04_2001_0000_0001_01_0000, 80'h06_200e_0000_0001_02_0000};
  always #4 clk_sys = ~clk_sys;
  dcsr_master dcsr_master_i (.clk_sys, .rsp_valid, .rsp_code, .rsp_rdata, .acc_valid, .acc_func, .acc_addr,
    .acc_wdata, .acc_qty);
  dcsr_bank dcsr_bank_i (.clk_sys, .rst, .acc_valid, .acc_func, .acc_addr, .acc_wdata, .acc_qty, .max_out_freq,
    .rsp_valid, .rsp_code, .rsp_rdata, .jog_stop_req, .power_accum_clear, .frequency_reference, .pid_setpoint,
    .pid_feedback, .torque_setpoint, .forward_freq_ceiling, .reverse_freq_ceiling, .motoring_torque_ceiling,
    .braking_torque_ceiling, .motor_select, .torque_ctrl_disable, .pre_excite_req, .dc_brake_req,
    .virtual_input_image, .virtual_output_image, .voltage_setpoint, .analog_out_one_setpoint);
  // ==========================================================
  // compare and verdict
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    give_verdict;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("freq_ref_rst", frequency_reference, 16'h0000);
    chk("ctl_rst", {motor_select, torque_ctrl_disable, pre_excite_req, dc_brake_req}, 16'h0000);
    for (int i = 0; i < 21; i++) begin
      dcsr_master_i.xfer(rows[i][79:72], rows[i][71:56], rows[i][55:40], rows[i][39:24], code, rdata);
      chk("rsp_code", {8'h00, code}, {8'h00, rows[i][23:16]});
      if (rows[i][79:72] == 8'h03 || rows[i][23:16] != 8'h00) chk("rsp_rdata", rdata, rows[i][15:0]);
    end
    chk("freq_ref", frequency_reference, 16'h1388);
    chk("torque", torque_setpoint, 16'hf448);
    chk("pid_fb", pid_feedback, 16'h0001);
    chk("fwd_ceil", forward_freq_ceiling, 16'h0000);
    chk("vout", {12'h000, virtual_output_image}, 16'h000f);
    dcsr_master_i.xfer(8'h06, 16'h2006, 16'h1388, 16'h0001, code, rdata);
    chk("rev_ceil", reverse_freq_ceiling, 16'h1388);
    dcsr_master_i.xfer(8'h06, 16'h2009, 16'h0035, 16'h0001, code, rdata);
    chk("ctl", {motor_select, torque_ctrl_disable, pre_excite_req, dc_brake_req, power_accum_clear}, 16'h001e);
    dcsr_master_i.xfer(8'h06, 16'h2009, 16'hfffa, 16'h0001, code, rdata);
    chk("ctl_b3", {motor_select, torque_ctrl_disable, pre_excite_req, dc_brake_req, power_accum_clear}, 16'h0027);
    dcsr_master_i.xfer(8'h10, 16'h2009, 16'h000b, 16'h0001, code, rdata);
    chk("pclr_again", {15'h0000, power_accum_clear}, 16'h0001);
    dcsr_master_i.xfer(8'h03, 16'h2009, 16'h0000, 16'h0001, code, rdata);
    chk("ctl_rd", rdata, 16'h000b);
    dcsr_master_i.xfer(8'h06, 16'h2000, 16'h0008, 16'h0001, code, rdata);
    chk("jog_stop", {15'h0000, jog_stop_req}, 16'h0001);
    dcsr_master_i.xfer(8'h06, 16'h2000, 16'h0005, 16'h0001, code, rdata);
    chk("jog_other", {15'h0000, jog_stop_req}, 16'h0000);
    chk("volt", voltage_setpoint, 16'h0000);
    chk("ao1", analog_out_one_setpoint, 16'hfc18);
    chk("mot_tq", motoring_torque_ceiling, 16'h0000);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("brk_tq_rst", braking_torque_ceiling, 16'h0000);
    chk("vin_rst", {6'h00, virtual_input_image}, 16'h0000);
    give_verdict;
  end
endmodule // tb_dcsr_bank
